// [verilog/rgc_pkg.sv]
// Shared constants for the GMII to RGMII converter and its far end
package rgc_pkg;
	// Link timing; the divided link clock stands in for the 125 MHz clock
	localparam int SYS_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 80;
	// Half period, least time rounded up
	localparam int HALF_CYC = (LINK_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	// Buffered word: {er, en, data}
	localparam int WORD_W = 10;
	localparam int WORD_EN_BIT = 8;
	localparam int WORD_ER_BIT = 9;
	localparam logic [WORD_W-1:0] IDLE_WORD = 10'h000;
	localparam int FIFO_DEPTH = 8;
	// Which half of the link clock period the serializer is in
	typedef enum logic {HALF_LOW, HALF_HIGH} rgc_half_t;
endpackage : rgc_pkg

// [verilog/rgc_link_if.sv]
// Six-signal double-data-rate link between the converter and its far end
`timescale 1ns/1ps
interface rgc_link_if;
	logic txc;
	logic [3:0] txd;
	logic tx_ctl;
	logic rxc;
	logic [3:0] rxd;
	logic rx_ctl;
	modport conv_end (output txc, txd, tx_ctl, input rxc, rxd, rx_ctl);
	modport phy_end (input txc, txd, tx_ctl, output rxc, rxd, rx_ctl);
endinterface : rgc_link_if

// [verilog/rgc_conv.sv]
// Converter end: DDR serializer, DDR deserializer and GMII-side top
`timescale 1ns/1ps

module rgc_ddr_tx #(
	parameter int HALF = rgc_pkg::HALF_CYC,
	parameter bit CTL_OR = 1'b0
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Word source, popped once per link period
	input wire logic [rgc_pkg::WORD_W-1:0] i_word,
	input wire logic i_valid,
	output logic o_pop,
	// Link pins
	output logic o_clk,
	output logic [rgc_pkg::NIB_W-1:0] o_nib,
	output logic o_ctl,
	// Enable of the word now on the link
	output logic o_active
);
	import rgc_pkg::*;
	localparam int CW = $clog2(HALF + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);
	// Data moves one system clock before each link clock edge so it is settled at both clock edges
	localparam logic [CW-1:0] MID = CW'(HALF / 2);
	logic [CW-1:0] cnt_q;
	rgc_half_t half_q;
	logic [WORD_W-1:0] cur_q;
	logic [WORD_W-1:0] next_word;
	logic mid;
	logic er_cur;

	assign mid = (cnt_q == MID);
	assign o_pop = mid & (half_q == HALF_LOW) & i_valid;
	assign next_word = i_valid ? i_word : IDLE_WORD;
	assign er_cur = cur_q[WORD_ER_BIT];

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
			half_q <= HALF_LOW;
			o_clk <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
			half_q <= (half_q == HALF_LOW) ? HALF_HIGH : HALF_LOW;
			o_clk <= ~o_clk;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cur_q <= IDLE_WORD;
			o_nib <= '0;
			o_ctl <= 1'b0;
		end else if (mid) begin
			case (half_q)
				HALF_LOW: begin
					cur_q <= next_word;
					o_nib <= next_word[NIB_W-1:0];
					o_ctl <= next_word[WORD_EN_BIT];
				end
				HALF_HIGH: begin
					o_nib <= cur_q[BYTE_W-1:NIB_W];
					if (CTL_OR) begin
						o_ctl <= cur_q[WORD_EN_BIT] | er_cur;
					end else begin
						o_ctl <= cur_q[WORD_EN_BIT] ^ er_cur;
					end
				end
				default: begin
					o_ctl <= 1'b0;
				end
			endcase
		end
	end

	assign o_active = cur_q[WORD_EN_BIT];
endmodule : rgc_ddr_tx

module rgc_ddr_rx (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Link pins, foreign timing
	input wire logic i_clk,
	input wire logic [rgc_pkg::NIB_W-1:0] i_nib,
	input wire logic i_ctl,
	// Rebuilt byte
	output logic [rgc_pkg::BYTE_W-1:0] o_byte,
	output logic o_dv,
	output logic o_er,
	output logic o_stb,
	output logic o_clk_s
);
	import rgc_pkg::*;
	// Clock, data and control share one synchroniser depth to stay aligned
	logic [NIB_W+1:0] s1_q;
	logic [NIB_W+1:0] s2_q;
	logic [NIB_W-1:0] lo_q;
	logic dv_q;
	logic rise;
	logic fall;

	assign rise = s2_q[NIB_W+1] & ~o_clk_s;
	assign fall = ~s2_q[NIB_W+1] & o_clk_s;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_q <= '0;
			s2_q <= '0;
			o_clk_s <= 1'b0;
		end else begin
			s1_q <= {i_clk, i_ctl, i_nib};
			s2_q <= s1_q;
			o_clk_s <= s2_q[NIB_W+1];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			lo_q <= '0;
			dv_q <= 1'b0;
			o_byte <= '0;
			o_dv <= 1'b0;
			o_er <= 1'b0;
			o_stb <= 1'b0;
		end else begin
			o_stb <= fall;
			if (rise) begin
				lo_q <= s2_q[NIB_W-1:0];
				dv_q <= s2_q[NIB_W];
			end
			if (fall) begin
				o_byte <= {s2_q[NIB_W-1:0], lo_q};
				o_dv <= dv_q;
				o_er <= dv_q ^ s2_q[NIB_W];
			end
		end
	end
endmodule : rgc_ddr_rx

module rgc_conv #(
	parameter int HALF = rgc_pkg::HALF_CYC,
	parameter int DEPTH = rgc_pkg::FIFO_DEPTH,
	parameter bit CTL_OR = 1'b0,
	parameter bit RX_CLK_GLOBAL = 1'b1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// GMII transmit from the MAC
	input wire logic [rgc_pkg::BYTE_W-1:0] i_gmii_txd,
	input wire logic i_gmii_tx_en,
	input wire logic i_gmii_tx_er,
	input wire logic i_gmii_tx_valid,
	output logic o_gmii_tx_ready,
	// GMII receive to the MAC
	output logic [rgc_pkg::BYTE_W-1:0] o_gmii_rxd,
	output logic o_gmii_rx_dv,
	output logic o_gmii_rx_er,
	output logic o_gmii_rx_stb,
	// Status, asynchronous to the MAC
	output logic o_gmii_col,
	output logic o_gmii_crs,
	// Forwarded receive clock, one network in use
	output logic o_rx_clk_global,
	output logic o_rx_clk_regional,
	// Link
	rgc_link_if.conv_end link
);
	import rgc_pkg::*;
	logic [WORD_W-1:0] f_word;
	logic f_valid;
	logic f_pop;
	logic tx_clk;
	logic [NIB_W-1:0] tx_nib;
	logic tx_ctl;
	logic tx_act;
	logic rx_clk_s;

	rgc_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_data({i_gmii_tx_er, i_gmii_tx_en, i_gmii_txd}),
		.i_valid(i_gmii_tx_valid),
		.o_ready(o_gmii_tx_ready),
		.o_data(f_word),
		.o_valid(f_valid),
		.i_ready(f_pop)
	);

	rgc_ddr_tx #(.HALF(HALF), .CTL_OR(CTL_OR)) u_tx (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_word(f_word),
		.i_valid(f_valid),
		.o_pop(f_pop),
		.o_clk(tx_clk),
		.o_nib(tx_nib),
		.o_ctl(tx_ctl),
		.o_active(tx_act)
	);

	assign link.txc = tx_clk;
	assign link.txd = tx_nib;
	assign link.tx_ctl = tx_ctl;

	rgc_ddr_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_clk(link.rxc),
		.i_nib(link.rxd),
		.i_ctl(link.rx_ctl),
		.o_byte(o_gmii_rxd),
		.o_dv(o_gmii_rx_dv),
		.o_er(o_gmii_rx_er),
		.o_stb(o_gmii_rx_stb),
		.o_clk_s(rx_clk_s)
	);

	// Derived from link activity; MAC must resynchronise both
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_gmii_col <= 1'b0;
			o_gmii_crs <= 1'b0;
		end else begin
			o_gmii_col <= tx_act & o_gmii_rx_dv;
			o_gmii_crs <= tx_act | o_gmii_rx_dv;
		end
	end

	// Unused network held low rather than left floating
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_clk_global <= 1'b0;
			o_rx_clk_regional <= 1'b0;
		end else begin
			o_rx_clk_global <= RX_CLK_GLOBAL & rx_clk_s;
			o_rx_clk_regional <= ~RX_CLK_GLOBAL & rx_clk_s;
		end
	end
endmodule : rgc_conv

// [verilog/rgc_phy_end.sv]
// Far end of the link and the word FIFO that both ends share
`timescale 1ns/1ps
module rgc_phy_end #(
	parameter int HALF = rgc_pkg::HALF_CYC,
	parameter int DEPTH = rgc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Bytes to send toward the converter
	input wire logic [rgc_pkg::BYTE_W-1:0] i_rx_data,
	input wire logic i_rx_dv,
	input wire logic i_rx_er,
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	// Bytes rebuilt from the converter
	output logic [rgc_pkg::BYTE_W-1:0] o_tx_data,
	output logic o_tx_en,
	output logic o_tx_er,
	output logic o_tx_stb,
	// Link
	rgc_link_if.phy_end link
);
	import rgc_pkg::*;
	logic [WORD_W-1:0] f_word;
	logic f_valid;
	logic f_pop;
	logic rx_clk;
	logic [NIB_W-1:0] rx_nib;
	logic rx_ctl;

	rgc_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_data({i_rx_er, i_rx_dv, i_rx_data}),
		.i_valid(i_rx_valid),
		.o_ready(o_rx_ready),
		.o_data(f_word),
		.o_valid(f_valid),
		.i_ready(f_pop)
	);

	// Valid on rise, valid XOR error on fall
	rgc_ddr_tx #(.HALF(HALF), .CTL_OR(1'b0)) u_tx (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_word(f_word),
		.i_valid(f_valid),
		.o_pop(f_pop),
		.o_clk(rx_clk),
		.o_nib(rx_nib),
		.o_ctl(rx_ctl),
		.o_active()
	);

	assign link.rxc = rx_clk;
	assign link.rxd = rx_nib;
	assign link.rx_ctl = rx_ctl;

	rgc_ddr_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_clk(link.txc),
		.i_nib(link.txd),
		.i_ctl(link.tx_ctl),
		.o_byte(o_tx_data),
		.o_dv(o_tx_en),
		.o_er(o_tx_er),
		.o_stb(o_tx_stb),
		.o_clk_s()
	);
endmodule : rgc_phy_end

module rgc_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Fill side
	input wire logic [W-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	// Drain side
	output logic [W-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	assign o_valid = (cnt_q != '0);
	assign o_data = mem_q[rd_q];
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	// Ready is registered from the next count so full is never overrun
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
			o_ready <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_ready <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
endmodule : rgc_fifo

// [verification/rgc_link_assertions.sv]
// Checker for link clock and data timing on both link directions
`timescale 1ns/1ps
module rgc_link_assertions (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Link
	input wire logic i_txc,
	input wire logic [3:0] i_txd,
	input wire logic i_tx_ctl,
	input wire logic i_rxc,
	input wire logic [3:0] i_rxd,
	input wire logic i_rx_ctl
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	property p_txc_high;
		$rose(i_txc) |=> i_txc [*3] ##1 !i_txc;
	endproperty
	a_txc_high: assert property (p_txc_high) else $error("txc high half wrong");
	property p_txc_low;
		$fell(i_txc) |=> !i_txc [*3] ##1 i_txc;
	endproperty
	a_txc_low: assert property (p_txc_low) else $error("txc low half wrong");
	property p_txd_set;
		$changed(i_txd) |=> $changed(i_txc);
	endproperty
	a_txd_set: assert property (p_txd_set) else $error("txd moved off half");
	property p_txctl_set;
		$changed(i_tx_ctl) |=> $changed(i_txc);
	endproperty
	a_txctl_set: assert property (p_txctl_set) else $error("tx_ctl moved off half");
	property p_rxc_high;
		$rose(i_rxc) |=> i_rxc [*3] ##1 !i_rxc;
	endproperty
	a_rxc_high: assert property (p_rxc_high) else $error("rxc high half wrong");
	property p_rxc_low;
		$fell(i_rxc) |=> !i_rxc [*3] ##1 i_rxc;
	endproperty
	a_rxc_low: assert property (p_rxc_low) else $error("rxc low half wrong");
	property p_rxd_set;
		$changed(i_rxd) |=> $changed(i_rxc);
	endproperty
	a_rxd_set: assert property (p_rxd_set) else $error("rxd moved off half");
	property p_rxctl_set;
		$changed(i_rx_ctl) |=> $changed(i_rxc);
	endproperty
	a_rxctl_set: assert property (p_rxctl_set) else $error("rx_ctl moved off half");
endmodule : rgc_link_assertions

// [verification/tb_top.sv]
// Bench joining converter and far end, random bytes both ways
`timescale 1ns/1ps
module tb_top;
	import rgc_pkg::*;
	localparam int N = 40;
	logic clk = 0;
	logic rstn = 0;
	logic [9:0] wd[2] = '{default: '0};
	logic vl[2] = '{default: 0};
	logic [9:0] q[4][$];
	logic [31:0] seed = 32'h866c_aa17;
	int cnt[2] = '{0, 0};
	int fails = 0;
	int n_checks = 0;
	logic [5:0] prv[2] = '{default: '0};
	logic [4:0] lo[2] = '{default: '0};
	logic seen[8] = '{default: 0};
	logic [9:0] nw;
	logic [9:0] ew;
	wire [1:0] rdy;
	wire [7:0] rxd, ptd;
	wire rdv, rer, rstb, col, crs, cg, cr, pen, per, pstb;
	wire [10:0] ou[2];
	wire [5:0] lk[2];
	wire cg_b, cr_b;
	rgc_link_if link();
	rgc_link_if link_b();
	assign ou[0] = {pstb, per, pen, ptd};
	assign ou[1] = {rstb, rer, rdv, rxd};
	assign lk[0] = {link.txc, link.tx_ctl, link.txd};
	assign lk[1] = {link.rxc, link.rx_ctl, link.rxd};

	rgc_conv rgc_conv_i (.i_clk_sys(clk), .i_rstn(rstn), .i_gmii_txd(wd[0][7:0]),
		.i_gmii_tx_en(wd[0][8]), .i_gmii_tx_er(wd[0][9]), .i_gmii_tx_valid(vl[0]),
		.o_gmii_tx_ready(rdy[0]), .o_gmii_rxd(rxd), .o_gmii_rx_dv(rdv), .o_gmii_rx_er(rer),
		.o_gmii_rx_stb(rstb), .o_gmii_col(col), .o_gmii_crs(crs), .o_rx_clk_global(cg),
		.o_rx_clk_regional(cr), .link(link));
	rgc_phy_end rgc_phy_end_i (.i_clk_sys(clk), .i_rstn(rstn), .i_rx_data(wd[1][7:0]),
		.i_rx_dv(wd[1][8]), .i_rx_er(wd[1][9]), .i_rx_valid(vl[1]), .o_rx_ready(rdy[1]),
		.o_tx_data(ptd), .o_tx_en(pen), .o_tx_er(per), .o_tx_stb(pstb), .link(link));
	// Second converter with OR control and the regional clock, fed the same stream
	if (1) begin : g_alt
		rgc_conv #(.CTL_OR(1'b1), .RX_CLK_GLOBAL(1'b0)) rgc_conv_i (.i_clk_sys(clk),
			.i_rstn(rstn), .i_gmii_txd(wd[0][7:0]), .i_gmii_tx_en(wd[0][8]),
			.i_gmii_tx_er(wd[0][9]), .i_gmii_tx_valid(vl[0]), .o_gmii_tx_ready(),
			.o_gmii_rxd(), .o_gmii_rx_dv(), .o_gmii_rx_er(), .o_gmii_rx_stb(),
			.o_gmii_col(), .o_gmii_crs(), .o_rx_clk_global(cg_b),
			.o_rx_clk_regional(cr_b), .link(link_b));
	end
	assign link_b.rxc = link.rxc;
	assign link_b.rxd = link.rxd;
	assign link_b.rx_ctl = link.rx_ctl;
	rgc_link_assertions rgc_link_assertions_i (.i_clk_sys(clk), .i_rstn(rstn),
		.i_txc(link.txc), .i_txd(link.txd), .i_tx_ctl(link.tx_ctl), .i_rxc(link.rxc),
		.i_rxd(link.rxd), .i_rx_ctl(link.rx_ctl));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// Enable or error always set, so a real word never looks idle
	function automatic logic [9:0] mk(input logic [31:0] x);
		return {x[9], x[8] | ~x[9], x[7:0]};
	endfunction : mk
	// Corner words first, random ones after
	function automatic logic [9:0] pick(input int c, input logic [31:0] x);
		case (c)
			0: return 10'h100;
			1: return 10'h1ff;
			2: return 10'h200;
			3: return 10'h3a5;
			default: return mk(x);
		endcase
	endfunction : pick

	task automatic chk_word(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_flag(input string nm, input logic e, input logic g);
		chk_word(nm, {9'h000, e}, {9'h000, g});
	endtask : chk_flag
	task automatic take(input int k, input logic [9:0] g, input string nm);
		if (g[9:8] === 2'b00) chk_word(nm, IDLE_WORD, g);
		else if (q[k].size() == 0) chk_word(nm, IDLE_WORD, g);
		else chk_word(nm, q[k].pop_front(), g);
	endtask : take
	task automatic test_done();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	initial begin
		forever #5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (rstn) begin
			for (int d = 0; d < 2; d++) begin
				seed = xs(seed);
				if (!rdy[d] && cnt[d] > 0) seen[d] = 1;
				// Valid is kept up while full so refusal is exercised
				if (cnt[d] < N && (cnt[d] < 16 || seed[31])) begin
					nw = pick(cnt[d], seed);
					vl[d] <= 1;
					wd[d] <= rdy[d] ? nw : 10'h3ff;
					if (rdy[d]) begin
						q[d].push_back(nw);
						q[d + 2].push_back(nw);
						cnt[d]++;
					end
				end else vl[d] <= 0;
				if (lk[d][5] && !prv[d][5]) lo[d] = lk[d][4:0];
				if (!lk[d][5] && prv[d][5]) begin
					// Both converters put the same word on the wire at the same time
					ew = (q[d].size() > 0 && (lo[d][4] | lk[d][4])) ? q[d][0] : IDLE_WORD;
					if (d == 0) chk_flag("or ctl", ew[8] | ew[9], link_b.tx_ctl);
					take(d, {lo[d][4] ^ lk[d][4], lo[d][4], lk[d][3:0], lo[d][3:0]}, "wire");
				end
				prv[d] = lk[d];
				if (ou[d][10]) take(d + 2, ou[d][9:0], "byte");
			end
			seen[2] |= col;
			seen[3] |= crs;
			seen[4] |= cg;
			seen[5] |= cr;
			seen[6] |= cr_b;
			seen[7] |= cg_b;
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk) rstn = 1;
		wait (cnt[0] == N && cnt[1] == N);
		for (int i = 0; i < 400 && q[0].size() + q[1].size() + q[2].size() + q[3].size() > 0; i++)
			@(negedge clk);
		repeat (20) @(negedge clk);
		chk_word("left", 10'(q[0].size() + q[1].size() + q[2].size() + q[3].size()), 10'h000);
		chk_flag("tx full", 1'b1, seen[0]);
		chk_flag("rx full", 1'b1, seen[1]);
		chk_flag("col seen", 1'b1, seen[2]);
		chk_flag("crs seen", 1'b1, seen[3]);
		chk_flag("col idle", 1'b0, col);
		chk_flag("crs idle", 1'b0, crs);
		chk_flag("global clk", 1'b1, seen[4]);
		chk_flag("regional clk", 1'b0, seen[5]);
		chk_flag("regional clk b", 1'b1, seen[6]);
		chk_flag("global clk b", 1'b0, seen[7]);
		test_done();
	end

	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule : tb_top
